// ===== design/ssc_pkg.sv
// Contract
// - Sweep mode takes three logic inputs: start, stop and hold/resume.
// - Sweep mode: start falling edge restarts the sweep from its beginning.
// - Sweep start is ORed with the external trigger input.
// - Sweep mode: stop falling edge stops the running sweep.
// - Sweep hold falling edge pauses; another falling edge resumes from paused point.
// - Sequence mode takes four inputs: start/state branch, stop, hold/resume, event branch.
// - A setting selects start or state branch for the shared sequence input.
// - Start selected: falling edge starts sequence from beginning, ORed with trigger.
// - State branch selected: input low at step end jumps to branch target.
// - Sequence mode: stop falling edge stops the sequence.
// - Sequence mode: hold falling edge pauses a running sequence.
// - Paused sequence resumes from paused point on hold rising edge.
// - Sequence mode: event branch falling edge jumps at once to target step.
// - Sequence mode drives the per-step 4-bit code while that step is active.
// - Step code bit zero is least significant, bit three most significant.
package ssc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] SSC_CTRL_OFS   = 8'h00;
	localparam logic [7:0] SSC_STAT_OFS   = 8'h04;
	localparam logic [7:0] SSC_SWLEN_OFS  = 8'h08;
	localparam logic [7:0] SSC_SQLAST_OFS = 8'h0c;
	localparam logic [7:0] SSC_STEP_OFS   = 8'h40;

	localparam int SSC_NSTEP = 16;
	localparam int SSC_SW_W  = 16;

	// ----------------------------------------------------------------
	// Pin indices and idle level
	// ----------------------------------------------------------------
	localparam int   SSC_PIN_START = 0;
	localparam int   SSC_PIN_STOP  = 1;
	localparam int   SSC_PIN_HOLD  = 2;
	localparam int   SSC_PIN_EVBR  = 3;
	localparam int   SSC_PIN_TRIG  = 4;
	localparam int   SSC_NPIN      = 5;
	localparam logic SSC_PIN_IDLE  = 1'b1;

	// ----------------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic trig_en;
		logic br_sel;
		logic in_en;
		logic seq_mode;
	} ssc_ctrl_t;

	typedef struct packed {
		logic [3:0]  evt_tgt;
		logic [3:0]  st_tgt;
		logic [3:0]  code;
		logic [15:0] dur;
	} ssc_step_t;

	typedef enum logic [1:0] {
		SSC_IDLE = 2'b00,
		SSC_RUN  = 2'b01,
		SSC_HOLD = 2'b10
	} ssc_run_t;

	typedef struct packed {
		logic [15:0] pos;
		logic [3:0]  rsv;
		logic [3:0]  code;
		logic [3:0]  step;
		ssc_run_t    seq;
		ssc_run_t    swp;
	} ssc_stat_t;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam ssc_ctrl_t   SSC_CTRL_RST   = 4'h0;
	localparam logic [15:0] SSC_SWLEN_RST  = 16'h03e7;
	localparam logic [3:0]  SSC_SQLAST_RST = 4'h0;
	localparam ssc_step_t   SSC_STEP_RST   = 28'h0000000;

endpackage

// ===== design/ssc_pin_sync.sv
`timescale 1ns/100ps
module ssc_pin_sync import ssc_pkg::*; (
	input  logic clk_i,
	input  logic rst_i,
	input  logic pin_i,
	output logic lvl_o,
	output logic fall_o,
	output logic rise_o
);
	logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
	logic lvl_q, lvl_d, fall_q, fall_d, rise_q, rise_d;

	// ----------------------------------------------------------------
	// Three-stage sync, level taken once stages two and three agree
	// ----------------------------------------------------------------
	always_comb begin
		s1_d   = pin_i;
		s2_d   = s1_q;
		s3_d   = s2_q;
		lvl_d  = (s2_q == s3_q) ? s3_q : lvl_q;
		fall_d = lvl_q & ~lvl_d;
		rise_d = ~lvl_q & lvl_d;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q   <= SSC_PIN_IDLE;
			s2_q   <= SSC_PIN_IDLE;
			s3_q   <= SSC_PIN_IDLE;
			lvl_q  <= SSC_PIN_IDLE;
			fall_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			s1_q   <= s1_d;
			s2_q   <= s2_d;
			s3_q   <= s3_d;
			lvl_q  <= lvl_d;
			fall_q <= fall_d;
			rise_q <= rise_d;
		end
	end

	assign lvl_o  = lvl_q;
	assign fall_o = fall_q;
	assign rise_o = rise_q;

	a_sync_fall : assert property (@(posedge clk_i) disable iff (rst_i)
		fall_o |-> !$past(pin_i, 3) && !$past(pin_i, 4))
		else $error("fall without settled low input");
endmodule // ssc_pin_sync

// ===== design/ssc_prog_cnt.sv
`timescale 1ns/100ps
module ssc_prog_cnt import ssc_pkg::*; #(
	parameter int W = SSC_SW_W
) (
	input  logic         clk_i,
	input  logic         rst_i,
	input  logic         clear_i,
	input  logic         run_i,
	input  logic [W-1:0] limit_i,
	output logic [W-1:0] count_o,
	output logic         done_o
);
	logic [W-1:0] cnt_q, cnt_d;

	// Done in the cycle the count sits on the limit while run_i is high
	assign done_o = run_i & (cnt_q == limit_i);

	always_comb begin
		cnt_d = cnt_q;
		if (clear_i)
			cnt_d = '0;
		else if (run_i && !done_o)
			cnt_d = cnt_q + 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	assign count_o = cnt_q;
endmodule // ssc_prog_cnt

// ===== design/ssc_top.sv
`timescale 1ns/100ps
module ssc_top import ssc_pkg::*; (
	input  logic        clk_i,
	input  logic        rst_i,
	input  logic        wb_cyc_i,
	input  logic        wb_stb_i,
	input  logic        wb_we_i,
	input  logic [7:0]  wb_adr_i,
	input  logic [3:0]  wb_sel_i,
	input  logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic        wb_ack_o,
	input  logic        start_pin_n_i,
	input  logic        stop_pin_n_i,
	input  logic        hold_pin_n_i,
	input  logic        evbr_pin_n_i,
	input  logic        trig_pin_n_i,
	output logic [3:0]  step_code_o,
	output logic [3:0]  seq_step_o,
	output logic        seq_run_o,
	output logic        sweep_run_o,
	output logic [15:0] sweep_pos_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [SSC_NPIN-1:0] pins;
	logic [SSC_NPIN-1:0] lvl;
	logic [SSC_NPIN-1:0] fall;
	logic [SSC_NPIN-1:0] rise;

	assign pins = {trig_pin_n_i, evbr_pin_n_i, hold_pin_n_i, stop_pin_n_i, start_pin_n_i};

	for (genvar g = 0; g < SSC_NPIN; g++) begin : g_sync
		ssc_pin_sync u_sync (
			.clk_i  (clk_i),
			.rst_i  (rst_i),
			.pin_i  (pins[g]),
			.lvl_o  (lvl[g]),
			.fall_o (fall[g]),
			.rise_o (rise[g])
		);
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	ssc_ctrl_t   ctrl_q, ctrl_d;
	logic [15:0] swlen_q, swlen_d;
	logic [3:0]  sqlast_q, sqlast_d;
	ssc_step_t   step_q [SSC_NSTEP];
	ssc_step_t   step_d [SSC_NSTEP];
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;

	ssc_run_t    swp_q, swp_d;
	ssc_run_t    seq_q, seq_d;
	logic [3:0]  idx_q, idx_d;
	logic [3:0]  code_q, code_d;

	logic        req;
	logic        wr;
	logic        step_sel;
	logic        step_we;
	logic [3:0]  step_adr;
	ssc_stat_t   stat;
	ssc_step_t   cur;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr       = req & wb_we_i;
	assign step_sel = (wb_adr_i[7:6] == SSC_STEP_OFS[7:6]);
	assign step_we  = wr & step_sel;
	assign step_adr = wb_adr_i[5:2];

	always_comb begin
		logic [31:0] tmp;
		tmp      = 32'h00000000;
		ack_d    = req;
		ctrl_d   = ctrl_q;
		swlen_d  = swlen_q;
		sqlast_d = sqlast_q;
		for (int i = 0; i < SSC_NSTEP; i++)
			step_d[i] = step_q[i];
		if (wr) begin
			case ({wb_adr_i[7:2], 2'b00})
				SSC_CTRL_OFS: begin
					tmp    = merge({28'h0000000, ctrl_q}, wb_dat_i, wb_sel_i);
					ctrl_d = tmp[3:0];
				end
				SSC_SWLEN_OFS: begin
					tmp     = merge({16'h0000, swlen_q}, wb_dat_i, wb_sel_i);
					swlen_d = tmp[15:0];
				end
				SSC_SQLAST_OFS: begin
					tmp      = merge({28'h0000000, sqlast_q}, wb_dat_i, wb_sel_i);
					sqlast_d = tmp[3:0];
				end
				default: begin
					if (step_sel) begin
						tmp              = merge({4'h0, step_q[step_adr]}, wb_dat_i, wb_sel_i);
						step_d[step_adr] = tmp[27:0];
					end
				end
			endcase
		end
	end

	always_comb begin
		rdat_d = 32'h00000000;
		if (req && !wb_we_i) begin
			case ({wb_adr_i[7:2], 2'b00})
				SSC_CTRL_OFS:   rdat_d = {28'h0000000, ctrl_q};
				SSC_STAT_OFS:   rdat_d = stat;
				SSC_SWLEN_OFS:  rdat_d = {16'h0000, swlen_q};
				SSC_SQLAST_OFS: rdat_d = {28'h0000000, sqlast_q};
				default: begin
					if (step_sel)
						rdat_d = {4'h0, step_q[step_adr]};
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q    <= 1'b0;
			rdat_q   <= 32'h00000000;
			ctrl_q   <= SSC_CTRL_RST;
			swlen_q  <= SSC_SWLEN_RST;
			sqlast_q <= SSC_SQLAST_RST;
			for (int i = 0; i < SSC_NSTEP; i++)
				step_q[i] <= SSC_STEP_RST;
		end else begin
			ack_q    <= ack_d;
			rdat_q   <= rdat_d;
			ctrl_q   <= ctrl_d;
			swlen_q  <= swlen_d;
			sqlast_q <= sqlast_d;
			for (int i = 0; i < SSC_NSTEP; i++)
				step_q[i] <= step_d[i];
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ----------------------------------------------------------------
	// Control decode
	// ----------------------------------------------------------------
	logic sw_act, sq_act, trig_go;
	logic sw_start, sw_stop, sw_hold;
	logic sq_start, sq_stop, sq_hold, sq_resume, sq_evt, sq_low;

	assign sw_act    = ctrl_q.in_en & ~ctrl_q.seq_mode;
	assign sq_act    = ctrl_q.in_en & ctrl_q.seq_mode;
	assign trig_go   = ctrl_q.trig_en & fall[SSC_PIN_TRIG];
	assign sw_start  = (sw_act & fall[SSC_PIN_START]) | (~ctrl_q.seq_mode & trig_go);
	assign sw_stop   = sw_act & fall[SSC_PIN_STOP];
	assign sw_hold   = sw_act & fall[SSC_PIN_HOLD];
	assign sq_start  = (sq_act & ~ctrl_q.br_sel & fall[SSC_PIN_START]) | (ctrl_q.seq_mode & trig_go);
	assign sq_stop   = sq_act & fall[SSC_PIN_STOP];
	assign sq_hold   = sq_act & fall[SSC_PIN_HOLD];
	assign sq_resume = sq_act & rise[SSC_PIN_HOLD];
	assign sq_evt    = sq_act & fall[SSC_PIN_EVBR];
	assign sq_low    = sq_act & ctrl_q.br_sel & ~lvl[SSC_PIN_START];

	// ----------------------------------------------------------------
	// Sweep controller
	// ----------------------------------------------------------------
	logic swp_clr, swp_done;

	ssc_prog_cnt #(.W(SSC_SW_W)) u_swp_cnt (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clear_i (swp_clr),
		.run_i   (swp_q == SSC_RUN),
		.limit_i (swlen_q),
		.count_o (sweep_pos_o),
		.done_o  (swp_done)
	);

	always_comb begin
		swp_d   = swp_q;
		swp_clr = 1'b0;
		if (ctrl_q.seq_mode || sw_stop) begin
			swp_d = SSC_IDLE;
		end else if (sw_start) begin
			swp_d   = SSC_RUN;
			swp_clr = 1'b1;
		end else begin
			case (swp_q)
				SSC_RUN: begin
					if (sw_hold)
						swp_d = SSC_HOLD;
					else if (swp_done)
						swp_d = SSC_IDLE;
				end
				SSC_HOLD: begin
					if (sw_hold)
						swp_d = SSC_RUN;
				end
				default: swp_d = SSC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sequence controller
	// ----------------------------------------------------------------
	logic seq_clr, seq_done;

	assign cur = step_q[idx_q];

	ssc_prog_cnt #(.W(SSC_SW_W)) u_seq_cnt (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clear_i (seq_clr),
		.run_i   (seq_q == SSC_RUN),
		.limit_i (cur.dur),
		.count_o (),
		.done_o  (seq_done)
	);

	always_comb begin
		seq_d   = seq_q;
		idx_d   = idx_q;
		seq_clr = 1'b0;
		if (!ctrl_q.seq_mode || sq_stop) begin
			seq_d = SSC_IDLE;
		end else if (sq_start) begin
			seq_d   = SSC_RUN;
			idx_d   = 4'h0;
			seq_clr = 1'b1;
		end else if (seq_q != SSC_IDLE && sq_evt) begin
			idx_d   = cur.evt_tgt;
			seq_clr = 1'b1;
		end else begin
			case (seq_q)
				SSC_RUN: begin
					if (sq_hold) begin
						seq_d = SSC_HOLD;
					end else if (seq_done) begin
						seq_clr = 1'b1;
						if (sq_low)
							idx_d = cur.st_tgt;
						else if (idx_q == sqlast_q)
							seq_d = SSC_IDLE;
						else
							idx_d = idx_q + 4'h1;
					end
				end
				SSC_HOLD: begin
					if (sq_resume)
						seq_d = SSC_RUN;
				end
				default: seq_d = SSC_IDLE;
			endcase
		end
	end

	// Code follows the step that will be active next cycle
	assign code_d = (seq_d != SSC_IDLE) ? step_q[idx_d].code : 4'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			swp_q  <= SSC_IDLE;
			seq_q  <= SSC_IDLE;
			idx_q  <= 4'h0;
			code_q <= 4'h0;
		end else begin
			swp_q  <= swp_d;
			seq_q  <= seq_d;
			idx_q  <= idx_d;
			code_q <= code_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs and status
	// ----------------------------------------------------------------
	assign step_code_o = code_q;
	assign seq_step_o  = idx_q;
	assign seq_run_o   = (seq_q == SSC_RUN);
	assign sweep_run_o = (swp_q == SSC_RUN);

	assign stat.pos  = sweep_pos_o;
	assign stat.rsv  = 4'h0;
	assign stat.code = code_q;
	assign stat.step = idx_q;
	assign stat.seq  = seq_q;
	assign stat.swp  = swp_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_sweep_start : assert property (sw_start && !sw_stop |=> swp_q == SSC_RUN && sweep_pos_o == 16'h0000)
		else $error("sweep did not restart");
	a_trig_start : assert property (ctrl_q.trig_en && !ctrl_q.seq_mode && fall[SSC_PIN_TRIG] && !sw_stop
		|=> swp_q == SSC_RUN)
		else $error("trigger did not start sweep");
	a_sweep_stop : assert property (sw_stop
		|=> (swp_q == SSC_IDLE) ##1 (!sweep_run_o || $past(sw_start)))
		else $error("sweep did not stop");
	a_sweep_hold : assert property (swp_q == SSC_RUN && sw_hold && !sw_start && !sw_stop && !ctrl_q.seq_mode
		|=> swp_q == SSC_HOLD)
		else $error("sweep did not pause");
	a_sweep_freeze : assert property (swp_q == SSC_HOLD && !sw_start |=> sweep_pos_o == $past(sweep_pos_o))
		else $error("sweep position moved while paused");
	a_seq_stop : assert property (sq_stop |=> seq_q == SSC_IDLE && step_code_o == 4'h0)
		else $error("sequence did not stop");
	a_seq_hold : assert property (seq_q == SSC_RUN && sq_hold && !sq_stop && !sq_start && !sq_evt
		|=> seq_q == SSC_HOLD)
		else $error("sequence did not pause");
	a_seq_resume : assert property (seq_q == SSC_HOLD && sq_resume && !sq_stop && !sq_start && !sq_evt
		|=> seq_q == SSC_RUN && seq_step_o == $past(seq_step_o))
		else $error("sequence did not resume in place");
	a_evt_branch : assert property (seq_q != SSC_IDLE && sq_evt && !sq_stop && !sq_start
		|=> seq_step_o == $past(cur.evt_tgt))
		else $error("event branch target missed");
	a_state_branch : assert property (seq_q == SSC_RUN && seq_done && sq_low && !sq_hold && !sq_stop
		&& !sq_start && !sq_evt |=> seq_step_o == $past(cur.st_tgt))
		else $error("state branch target missed");
	a_step_code : assert property (seq_q != SSC_IDLE && !$past(step_we) |-> step_code_o == cur.code)
		else $error("step code does not match active step");

	c_sweep_end : cover property (swp_q == SSC_RUN && swp_done ##1 swp_q == SSC_IDLE);
	c_seq_hold : cover property (seq_q == SSC_HOLD ##[1:50] seq_q == SSC_RUN);
	c_evt_branch : cover property (seq_q == SSC_RUN && sq_evt);
	c_state_branch : cover property (seq_q == SSC_RUN && seq_done && sq_low);

endmodule // ssc_top

// ===== verification/ssc_ctl_model.sv
`timescale 1ns/100ps
module ssc_ctl_model import ssc_pkg::*; (
	input  logic                clk_i,
	output logic [SSC_NPIN-1:0] pin_n_o
);
	// ----------------------------------------------------------------
	// Pulled-up control lines, idle high
	// ----------------------------------------------------------------
	initial pin_n_o = {SSC_NPIN{SSC_PIN_IDLE}};

	task automatic set_pin(input int idx, input logic lvl);
		@(posedge clk_i);
		pin_n_o[idx] <= lvl;
	endtask

	// Low for four cycles, then released
	task automatic pulse(input int idx);
		set_pin(idx, 1'b0);
		repeat (4) @(posedge clk_i);
		pin_n_o[idx] <= SSC_PIN_IDLE;
		repeat (4) @(posedge clk_i);
	endtask
endmodule // ssc_ctl_model

// ===== verification/tb_sweep_sequence_control_io.sv
`timescale 1ns/100ps
module tb_sweep_sequence_control_io import ssc_pkg::*;;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic                cyc = 1'b0;
	logic                stb = 1'b0;
	logic                we  = 1'b0;
	logic [7:0]          adr = 8'h00;
	logic [31:0]         wdat = 32'h00000000;
	logic [31:0]         rdat;
	logic                ack;
	logic [SSC_NPIN-1:0] pin_n;
	logic [3:0]          code;
	logic [3:0]          step;
	logic                seq_run;
	logic                swp_run;
	logic [15:0]         pos;
	logic [15:0]         p;
	logic [31:0]         d;
	int                  err_count = 0;
	int                  check_count = 0;

	always #5 clk = ~clk;

	ssc_ctl_model i_ctl (.clk_i(clk), .pin_n_o(pin_n));

	ssc_top i_dut (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.start_pin_n_i(pin_n[SSC_PIN_START]), .stop_pin_n_i(pin_n[SSC_PIN_STOP]),
		.hold_pin_n_i(pin_n[SSC_PIN_HOLD]), .evbr_pin_n_i(pin_n[SSC_PIN_EVBR]),
		.trig_pin_n_i(pin_n[SSC_PIN_TRIG]), .step_code_o(code), .seq_step_o(step),
		.seq_run_o(seq_run), .sweep_run_o(swp_run), .sweep_pos_o(pos)
	);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ----------------------------------------------------------------
	// Classic Wishbone single cycle
	// ----------------------------------------------------------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(32'h0, 32'h1);
			wrap_up();
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		wb(1'b1, a, wd, x);
	endtask

	task automatic t_reset();
		chk({code, step, seq_run, swp_run, pos}, 32'h0);
		wb(1'b0, SSC_CTRL_OFS, 32'h0, d);
		chk(d, 32'h0);
		wb(1'b0, SSC_SWLEN_OFS, 32'h0, d);
		chk(d, {16'h0, SSC_SWLEN_RST});
		wb(1'b0, 8'h80, 32'h0, d);
		chk(d, 32'h0);
	endtask

	task automatic t_sweep();
		ssc_stat_t st;
		wr(SSC_SWLEN_OFS, 32'h000000c8);
		wr(SSC_CTRL_OFS, 32'h00000002);
		i_ctl.pulse(SSC_PIN_START);
		chk(swp_run, 1'b1);
		wb(1'b0, SSC_STAT_OFS, 32'h0, d);
		st = d;
		chk(st.swp, SSC_RUN);
		i_ctl.pulse(SSC_PIN_HOLD);
		chk(swp_run, 1'b0);
		p = pos;
		repeat (10) @(posedge clk);
		chk(pos, p);
		i_ctl.pulse(SSC_PIN_HOLD);
		chk(swp_run, 1'b1);
		chk(pos >= p && pos < p + 16'h0008, 1'b1);
		repeat (20) @(posedge clk);
		i_ctl.pulse(SSC_PIN_START);
		chk(pos < 16'h0008, 1'b1);
		i_ctl.pulse(SSC_PIN_STOP);
		chk(swp_run, 1'b0);
		wr(SSC_CTRL_OFS, 32'h00000000);
		i_ctl.pulse(SSC_PIN_START);
		chk(swp_run, 1'b0);
	endtask

	task automatic t_trig();
		wr(SSC_SWLEN_OFS, 32'h0000001e);
		wr(SSC_CTRL_OFS, 32'h0000000a);
		i_ctl.pulse(SSC_PIN_TRIG);
		chk(swp_run, 1'b1);
		repeat (40) @(posedge clk);
		chk(swp_run, 1'b0);
		chk(pos, 16'h001e);
	endtask

	task automatic t_seq();
		ssc_step_t s;
		for (int n = 0; n < 4; n++) begin
			s = '{evt_tgt: 4'h3, st_tgt: 4'h2, code: 4'h1 << n, dur: 16'h0028};
			wr(SSC_STEP_OFS + 8'(4 * n), {4'h0, s});
		end
		wr(SSC_SQLAST_OFS, 32'h00000003);
		wr(SSC_CTRL_OFS, 32'h00000003);
		i_ctl.pulse(SSC_PIN_START);
		chk({seq_run, step, code}, 9'h101);
		i_ctl.set_pin(SSC_PIN_HOLD, 1'b0);
		repeat (8) @(posedge clk);
		chk(seq_run, 1'b0);
		repeat (60) @(posedge clk);
		chk(step, 4'h0);
		i_ctl.set_pin(SSC_PIN_HOLD, 1'b1);
		repeat (8) @(posedge clk);
		chk({seq_run, step}, 5'h10);
		i_ctl.pulse(SSC_PIN_EVBR);
		chk({step, code}, 8'h38);
		i_ctl.pulse(SSC_PIN_STOP);
		chk({seq_run, code}, 5'h00);
		i_ctl.pulse(SSC_PIN_START);
		repeat (41) @(posedge clk);
		chk({step, code}, 8'h12);
		i_ctl.pulse(SSC_PIN_STOP);
	endtask

	task automatic t_branch();
		wr(SSC_CTRL_OFS, 32'h00000007);
		i_ctl.pulse(SSC_PIN_START);
		chk(seq_run, 1'b0);
		wr(SSC_CTRL_OFS, 32'h0000000f);
		i_ctl.pulse(SSC_PIN_TRIG);
		chk({seq_run, step}, 5'h10);
		i_ctl.set_pin(SSC_PIN_START, 1'b0);
		repeat (45) @(posedge clk);
		chk({step, code}, 8'h24);
		i_ctl.set_pin(SSC_PIN_START, 1'b1);
		i_ctl.pulse(SSC_PIN_STOP);
		chk(seq_run, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_sweep();
		t_trig();
		t_seq();
		t_branch();
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end
endmodule // tb_sweep_sequence_control_io
